/* File: rtl/dfc_top.sv */
// Purpose: Setup, gain and offset registers of a decimation filter chain
// Assumes: Single clock, AXI4-Lite master keeps the channel handshake rules
// Notes: Lane, rate and stage outputs are registered decodes; the other controls come straight off the stored fields
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// RQ1: rate field selects output word rate
// RQ2: stage field selects output filter stage
// RQ3: lane field selects active channels
// RQ4: gain enable applies per-channel gain words
// RQ5: offset enable applies per-channel offset words
// RQ6: autotrim enable runs offset calibration
// RQ7: shift field sets calibration sensitivity
// RQ8: reserved setup bits read zero
// RQ9: four gain words at consecutive addresses
// RQ10: four offset words at consecutive addresses
// RQ11: reset clears all fields
module dfc_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // AXI4-Lite write address
  input wire logic [9:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [9:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Filter chain controls
  output logic [3:0] LANE_ENABLE,
  output logic [7:0] RATE_ONEHOT,
  output logic [5:0] STAGE_ONEHOT,
  output logic STAGE_RESERVED,
  output logic GAIN_CORRECT_ON,
  output logic OFFSET_CORRECT_ON,
  output logic AUTOTRIM_RUN,
  output logic [4:0] TRIM_SHIFT,
  output logic [95:0] GAIN_WORDS,
  output logic [95:0] OFFSET_WORDS
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge a 24-bit word with a write under byte strobes
  // Strobe 3 is ignored because only the low 24 bits are stored
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [23:0] r;
    r = old;
    for (int b = 0; b < 3; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction
  // Word index of a byte address, used on both channels
  // Low address bits are dropped, so an unaligned request hits its word
  function automatic logic [7:0] word_idx(input logic [9:0] a);
    return a[9:2];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [23:0] setup_r, setup_nxt; // Filter setup word
  logic [23:0] gain_r [4]; // Per-lane gain words
  logic [23:0] gain_nxt [4];
  logic [23:0] ofst_r [4]; // Per-lane offset words
  logic [23:0] ofst_nxt [4];
  logic [9:0] awaddr_r, awaddr_nxt; // Captured write address
  logic aw_have_r, aw_have_nxt; // Write address held
  logic [31:0] wdata_r, wdata_nxt; // Captured write data
  logic [3:0] wstrb_r, wstrb_nxt;
  logic w_have_r, w_have_nxt; // Write data held
  // Write response
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // Read answer
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // Ready flags kept as flops so the bus outputs carry no gate
  logic awready_r, awready_nxt; // Write address slot free
  logic wready_r, wready_nxt; // Write data slot free
  logic arready_r, arready_nxt; // No read answer pending
  // Registered decodes
  logic [3:0] lane_r;
  logic [7:0] rate_r;
  logic [5:0] stage_r;
  logic stage_res_r;
  // Decoder outputs
  logic [3:0] lane_d;
  logic [7:0] rate_d;
  logic [5:0] stage_d;
  logic stage_res_d;
  logic do_write; // Both halves of a write present
  logic [7:0] widx, ridx;

  // ----------------------------------------------------------------
  // Field decoder
  // ----------------------------------------------------------------
  // Decoding sits behind setup_r, and its results are registered again
  dfc_decode u_decode (
    .lane_count(setup_r[dfc_pkg::LANE_LSB +: 2]),
    .rate_sel(setup_r[dfc_pkg::RATE_LSB +: 3]),
    .stage_sel(setup_r[dfc_pkg::STAGE_LSB +: 3]),
    .lane_en(lane_d),
    .rate_onehot(rate_d),
    .stage_onehot(stage_d),
    .stage_reserved(stage_res_d)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held until the
  // response is accepted, so one write is in flight at a time.
  always_comb begin
    awaddr_nxt = awaddr_r;
    aw_have_nxt = aw_have_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    setup_nxt = setup_r;
    gain_nxt = gain_r;
    ofst_nxt = ofst_r;
    // Write index comes from the held address, read index from the live one
    widx = word_idx(awaddr_r);
    ridx = word_idx(S_AXI_ARADDR);
    // Capture halves of the write
    if (S_AXI_AWVALID && !aw_have_r) begin
      awaddr_nxt = S_AXI_AWADDR;
      aw_have_nxt = 1'b1;
    end
    if (S_AXI_WVALID && !w_have_r) begin
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
      w_have_nxt = 1'b1;
    end
    // Commit once both halves are held and no answer is pending
    do_write = aw_have_r && w_have_r && !bvalid_r;
    if (do_write) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = dfc_pkg::RESP_OKAY;
      if (widx == dfc_pkg::IDX_SETUP) begin
        // RQ8: reserved bits never stored
        setup_nxt = merge(setup_r, wdata_r, wstrb_r) & dfc_pkg::SETUP_MASK;
      end else if (widx >= dfc_pkg::IDX_GAIN0 && widx < dfc_pkg::IDX_OFST0) begin
        // RQ9: gain word per lane
        gain_nxt[2'(widx - dfc_pkg::IDX_GAIN0)] =
          merge(gain_r[2'(widx - dfc_pkg::IDX_GAIN0)], wdata_r, wstrb_r);
      end else if (widx >= dfc_pkg::IDX_OFST0 && widx < dfc_pkg::IDX_OFST0 + 8'h04) begin
        // RQ10: offset word per lane
        ofst_nxt[2'(widx - dfc_pkg::IDX_OFST0)] =
          merge(ofst_r[2'(widx - dfc_pkg::IDX_OFST0)], wdata_r, wstrb_r);
      end else begin
        // Unmapped address
        bresp_nxt = dfc_pkg::RESP_SLVERR;
      end
    end
    // Response accepted frees the write path
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
    end
    // A read taken in the cycle a write commits returns the older value
    // Read: take address when no answer pending
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end else if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = dfc_pkg::RESP_OKAY;
      // Unmapped reads answer zero with an error response
      rdata_nxt = 32'h0000_0000;
      if (ridx == dfc_pkg::IDX_SETUP) begin
        // RQ8: reserved positions read zero
        rdata_nxt = {8'h00, setup_r & dfc_pkg::SETUP_MASK};
      end else if (ridx >= dfc_pkg::IDX_GAIN0 && ridx < dfc_pkg::IDX_OFST0) begin
        rdata_nxt = {8'h00, gain_r[2'(ridx - dfc_pkg::IDX_GAIN0)]};
      end else if (ridx >= dfc_pkg::IDX_OFST0 && ridx < dfc_pkg::IDX_OFST0 + 8'h04) begin
        rdata_nxt = {8'h00, ofst_r[2'(ridx - dfc_pkg::IDX_OFST0)]};
      end else begin
        rresp_nxt = dfc_pkg::RESP_SLVERR;
      end
    end
    // Ready follows the slot state it will have after this edge
    awready_nxt = !aw_have_nxt;
    wready_nxt = !w_have_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      // RQ11: all fields cleared
      setup_r <= dfc_pkg::SETUP_RESET;
      for (int i = 0; i < dfc_pkg::NUM_LANES; i++) begin
        gain_r[i] <= dfc_pkg::WORD_RESET;
        ofst_r[i] <= dfc_pkg::WORD_RESET;
      end
      // Bus state idle
      awaddr_r <= 10'h000;
      aw_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      // Slots start free so the first request is taken at once
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      // Decodes of an all-zero setup word
      lane_r <= dfc_pkg::LANE_RESET;
      rate_r <= dfc_pkg::RATE_RESET;
      stage_r <= dfc_pkg::STAGE_RESET;
      stage_res_r <= 1'b0;
    end else begin
      // Every register loads its next value on each edge
      setup_r <= setup_nxt;
      gain_r <= gain_nxt;
      ofst_r <= ofst_nxt;
      awaddr_r <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      // Decoded controls lag the setup word by one cycle
      lane_r <= lane_d;
      rate_r <= rate_d;
      stage_r <= stage_d;
      stage_res_r <= stage_res_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready is high while the half is not yet held; held halves stall the master
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  // RQ3: lane enables
  assign LANE_ENABLE = lane_r;
  // RQ1: word rate select
  assign RATE_ONEHOT = rate_r;
  // RQ2: stage select
  assign STAGE_ONEHOT = stage_r;
  assign STAGE_RESERVED = stage_res_r;
  // Correction enables come straight off the stored setup bits
  // RQ4: gain correction enable
  assign GAIN_CORRECT_ON = setup_r[dfc_pkg::GAIN_EN_BIT];
  // RQ5: offset correction enable
  assign OFFSET_CORRECT_ON = setup_r[dfc_pkg::OFST_EN_BIT];
  // RQ6: calibration run enable
  assign AUTOTRIM_RUN = setup_r[dfc_pkg::TRIM_EN_BIT];
  // RQ7: sensitivity exponent
  assign TRIM_SHIFT = setup_r[dfc_pkg::SHIFT_LSB +: 5];
  // Correction words flattened, lane 0 lowest
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_words
      assign GAIN_WORDS[g*24 +: 24] = gain_r[g];
      assign OFFSET_WORDS[g*24 +: 24] = ofst_r[g];
    end
  endgenerate
endmodule

/* File: rtl/dfc_pkg.sv */
// Purpose: Shared constants for the decimation filter configuration block
// Assumes: AXI4-Lite, 32-bit data, word registers at index*4
// Notes: Printed offsets are register indices, byte address is four times each
package dfc_pkg;
  // ----------------------------------------------------------------
  // Register indices, lane count and address width
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SETUP = 8'h20;
  localparam logic [7:0] IDX_GAIN0 = 8'h21;
  localparam logic [7:0] IDX_OFST0 = 8'h25;
  localparam int NUM_LANES = 4;
  localparam int AW = 10;
  // ----------------------------------------------------------------
  // Setup register layout
  // ----------------------------------------------------------------
  localparam logic [23:0] SETUP_RESET = 24'h00_0000;
  localparam logic [23:0] SETUP_MASK = 24'h1F_7773;
  localparam int LANE_LSB = 0;
  localparam int RATE_LSB = 4;
  localparam int STAGE_LSB = 8;
  localparam int GAIN_EN_BIT = 12;
  localparam int OFST_EN_BIT = 13;
  localparam int TRIM_EN_BIT = 14;
  localparam int SHIFT_LSB = 16;
  localparam logic [23:0] WORD_RESET = 24'h00_0000;
  // Decoded control values for an all-zero setup word
  localparam logic [3:0] LANE_RESET = 4'hF;
  localparam logic [7:0] RATE_RESET = 8'h01;
  localparam logic [5:0] STAGE_RESET = 6'h01;
  // ----------------------------------------------------------------
  // Stage codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STAGE_SINC = 3'h0;
  localparam logic [2:0] STAGE_IIR3 = 3'h5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/dfc_decode.sv */
// Purpose: Decode setup fields into lane enables and rate/stage one-hots
// Assumes: Pure combinational, inputs from registers on the same clock
// Notes: Reserved stage codes yield no stage selected
`timescale 1ns/1ps
module dfc_decode (
  // Setup fields
  input wire logic [1:0] lane_count,
  input wire logic [2:0] rate_sel,
  input wire logic [2:0] stage_sel,
  // Decoded controls
  output logic [3:0] lane_en,
  output logic [7:0] rate_onehot,
  output logic [5:0] stage_onehot,
  output logic stage_reserved
);
  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  always_comb begin
    // RQ3: lane enable map
    case (lane_count)
      2'h0: lane_en = 4'hF;
      2'h1: lane_en = 4'h1;
      2'h2: lane_en = 4'h3;
      default: lane_en = 4'h7;
    endcase
    // RQ1: rate code one-hot
    rate_onehot = 8'h01 << rate_sel;
    // RQ2: stage select, reserved codes select nothing
    stage_reserved = (stage_sel > dfc_pkg::STAGE_IIR3);
    stage_onehot = stage_reserved ? 6'h00 : 6'(6'h01 << stage_sel);
  end
endmodule

/* File: verif/dfc_top_props.sv */
// Purpose: Port-level checks of the filter setup block
// Assumes: One clock, active-low asynchronous reset
// Notes: A setup read ties the read data to the decoded controls
`timescale 1ns/1ps
module dfc_top_chk (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Read side of the register bus
  input wire logic [9:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  // Filter chain controls
  input wire logic [3:0] LANE_ENABLE,
  input wire logic [7:0] RATE_ONEHOT,
  input wire logic [5:0] STAGE_ONEHOT,
  input wire logic STAGE_RESERVED,
  input wire logic GAIN_CORRECT_ON,
  input wire logic OFFSET_CORRECT_ON,
  input wire logic AUTOTRIM_RUN,
  input wire logic [4:0] TRIM_SHIFT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Read taken now; data and decoded controls show the setup held at this edge, enables and shift the setup loaded at it
  wire ar_hit = S_AXI_ARVALID && S_AXI_ARREADY;
  wire su_rd = ar_hit && S_AXI_ARADDR[9:2] == 8'h20;
  // Index outside the mapped words
  wire bad_rd = ar_hit && (S_AXI_ARADDR[9:2] < 8'h20 || S_AXI_ARADDR[9:2] > 8'h28);
  chk_rate_decode: assert property (su_rd |=> RATE_ONEHOT == 8'h01 << S_AXI_RDATA[6:4])
    else $error("rate one-hot differs from setup");
  chk_stage_decode: assert property (su_rd |=>
    STAGE_RESERVED == (S_AXI_RDATA[10:9] == 2'b11) &&
    STAGE_ONEHOT == (S_AXI_RDATA[10:9] == 2'b11 ? 6'h00 : 6'h01 << S_AXI_RDATA[10:8]))
    else $error("stage select differs from setup");
  chk_lane_decode: assert property (su_rd |=> LANE_ENABLE ==
    (S_AXI_RDATA[1:0] == 2'b00 ? 4'hF : (4'h1 << S_AXI_RDATA[1:0]) - 4'h1))
    else $error("lane enables differ from setup");
  chk_gain_enable: assert property (su_rd |=> GAIN_CORRECT_ON == S_AXI_RDATA[12])
    else $error("gain enable differs from setup");
  chk_ofst_enable: assert property (su_rd |=> OFFSET_CORRECT_ON == S_AXI_RDATA[13])
    else $error("offset enable differs from setup");
  chk_trim_enable: assert property (su_rd |=> AUTOTRIM_RUN == S_AXI_RDATA[14])
    else $error("trim run differs from setup");
  chk_shift_field: assert property (su_rd |=> TRIM_SHIFT == S_AXI_RDATA[20:16])
    else $error("trim shift differs from setup");
  chk_reserved_zero: assert property (su_rd |=> (S_AXI_RDATA & 32'hFFE0_888C) == 32'h0)
    else $error("reserved setup bits read nonzero");
  chk_hole_error: assert property (bad_rd |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_reset_state: assert property ($rose(RESET_N) |-> LANE_ENABLE == 4'hF &&
    RATE_ONEHOT == 8'h01 && STAGE_ONEHOT == 6'h01 && !AUTOTRIM_RUN && TRIM_SHIFT == 5'h00 &&
    !GAIN_CORRECT_ON && !OFFSET_CORRECT_ON && !STAGE_RESERVED)
    else $error("controls not at reset defaults");
endmodule
bind dfc_top dfc_top_chk i_chk (.*);

/* File: verif/test_decimation_filter_config.sv */
// Purpose: Self-checking bench for the filter setup block
// Assumes: Bus results come back in the order they were requested
// Notes: Data is random from a fixed-seed xorshift
`timescale 1ns/1ps
module test_decimation_filter_config;
  // Block ports
  logic CLK_SYS, RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [9:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB, LANE_ENABLE;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [7:0] RATE_ONEHOT;
  logic [5:0] STAGE_ONEHOT;
  logic STAGE_RESERVED, GAIN_CORRECT_ON, OFFSET_CORRECT_ON, AUTOTRIM_RUN;
  logic [4:0] TRIM_SHIFT;
  logic [95:0] GAIN_WORDS, OFFSET_WORDS;
  // Counters, queued notes and the register model
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0001_1CF1;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [23:0] m[8];
  logic [23:0] su;
  logic [3:0] lanes[4] = '{4'hF, 4'h1, 4'h3, 4'h7};
  logic [9:0] holes[4] = '{10'h000, 10'h07C, 10'h0A4, 10'h3FC};

  dfc_top i_dut (.*);

  // 125 MHz system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // All controls and both word banks in one vector
  function automatic logic [218:0] ctl();
    return {LANE_ENABLE, RATE_ONEHOT, STAGE_ONEHOT, STAGE_RESERVED, GAIN_CORRECT_ON,
            OFFSET_CORRECT_ON, AUTOTRIM_RUN, TRIM_SHIFT, GAIN_WORDS, OFFSET_WORDS};
  endfunction

  // Expected controls for setup s; codes 6 and 7 select no stage
  function automatic logic [218:0] want(input logic [23:0] s);
    return {lanes[s[1:0]], 8'h01 << s[6:4], (s[10:9] == 2'b11) ? 6'h00 : 6'h01 << s[10:8],
            s[10:9] == 2'b11, s[12], s[13], s[14], s[20:16],
            m[3], m[2], m[1], m[0], m[7], m[6], m[5], m[4]};
  endfunction

  task automatic end_of_test();
    // Notes left on a queue are answers that never came
    if (bq.size() != 0 || rq.size() != 0) begin
      miscompares++;
    end
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ctl(input logic [218:0] got, input logic [218:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t controls got %h exp %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge CLK_SYS);
    bq.push_back(r);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) S_AXI_BREADY <= 1'b0;
    end while (!S_AXI_BVALID);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge CLK_SYS);
    rq.push_back({r, d});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) S_AXI_RREADY <= 1'b0;
    end while (!S_AXI_RVALID);
  endtask

  // Reset for four cycles, then everything must read as cleared
  task automatic rst_chk();
    RESET_N <= 1'b0;
    m = '{default: 24'h0};
    su = 24'h0;
    repeat (4) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    cmp_ctl(ctl(), want(su));
    rd(10'h080, 32'h0, 2'h0);
    rd(10'h0A0, 32'h0, 2'h0);
  endtask

  // Results are matched to the oldest note; the hang limit comes last
  always @(posedge CLK_SYS) begin
    cycles++;
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      cmp_bus({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      cmp_bus({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
    end
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] d;
    logic [3:0] s;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = 56'h0;
    rst_chk();
    // Every code of every field but the random shift, reserved bits written as random ones
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      {d[14:12], d[10:8], d[6:4], d[1:0]} = {i[2:0], i[2:0], i[2:0], i[1:0]};
      su = d[23:0] & 24'h1F_7773;
      wr(10'h080, d, 4'hF, 2'h0);
      rd(10'h080, {8'h00, su}, 2'h0);
      cmp_ctl(ctl(), want(su));
    end
    // Gain and offset words with random byte strobes, read straight back
    for (int k = 0; k < 16; k++) begin
      d = rnd();
      s = 4'(rnd());
      for (int b = 0; b < 3; b++) if (s[b]) m[k % 8][8 * b +: 8] = d[8 * b +: 8];
      wr(10'h084 + 10'(4 * (k % 8)), d, s, 2'h0);
      rd(10'h084 + 10'(4 * (k % 8)), {8'h00, m[k % 8]}, 2'h0);
    end
    cmp_ctl(ctl(), want(su));
    // Holes around the map are refused and leave the registers alone
    foreach (holes[j]) begin
      wr(holes[j], rnd(), 4'hF, 2'h2);
      rd(holes[j], 32'h0, 2'h2);
    end
    cmp_ctl(ctl(), want(su));
    rst_chk();
    // Let the monitor take the last answer before the verdict
    repeat (2) @(posedge CLK_SYS);
    end_of_test();
  end
endmodule
